// ### logic/opmt_pkg.sv
// Constants shared by the one-shot, PWM and measurement timer block.
package opmt_pkg;
	// Register indices; byte address is four times the index.
	localparam logic [9:0] IDX_B3_MODE = 10'h31b;
	localparam logic [9:0] IDX_B4_MODE = 10'h31c;
	localparam logic [9:0] IDX_B5_MODE = 10'h31d;
	localparam logic [9:0] IDX_B0_MODE = 10'h35b;
	localparam logic [9:0] IDX_B1_MODE = 10'h35c;
	localparam logic [9:0] IDX_B2_MODE = 10'h35d;
	localparam logic [9:0] IDX_START_PRI = 10'h340;
	localparam logic [9:0] IDX_ONESHOT = 10'h342;
	localparam logic [9:0] IDX_A_VALUE = 10'h346;
	localparam logic [9:0] IDX_B_VALUE = 10'h350;
	localparam logic [9:0] IDX_A_MODE = 10'h356;
	localparam logic [9:0] IDX_PRESC = 10'h35f;
	localparam logic [9:0] IDX_START_SEC = 10'h300;
	localparam int ADDR_W = 12;
	// Field positions.
	localparam int F_OP = 0;
	localparam int F_TRG_USE = 2;
	localparam int F_PIN_FALL = 3;
	localparam int F_PWM8 = 4;
	localparam int F_SRC = 6;
	localparam int F_MEAS = 2;
	localparam int F_MR2 = 4;
	localparam int F_OVF = 5;
	localparam int F_OS_START = 0;
	localparam int F_TRGSEL = 4;
	localparam int F_A_RUN = 0;
	localparam int F_B_RUN = 1;
	localparam int F_B_RUN2 = 0;
	localparam int F_DIV = 0;
	localparam int F_PRE_EN = 7;
	// Encodings.
	localparam logic [1:0] A_OP_ONESHOT = 2'h2;
	localparam logic [1:0] A_OP_PWM = 2'h3;
	localparam logic [1:0] B_OP_TIMER = 2'h0;
	localparam logic [1:0] B_OP_MEASURE = 2'h2;
	localparam logic [1:0] MEAS_FALL = 2'h0;
	localparam logic [1:0] MEAS_RISE = 2'h1;
	localparam logic [1:0] MEAS_BOTH = 2'h2;
	localparam logic [1:0] SRC_F1 = 2'h0;
	localparam logic [1:0] SRC_F8 = 2'h1;
	localparam logic [1:0] SRC_PRE = 2'h2;
	localparam logic [1:0] SRC_SUB = 2'h3;
	localparam logic [1:0] TRG_PIN = 2'h0;
	localparam logic [1:0] TRG_B2 = 2'h1;
	localparam logic [1:0] TRG_PREV = 2'h2;
	localparam logic [1:0] TRG_NEXT = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Counts and reset values.
	localparam logic [15:0] PWM16_PERIOD = 16'hffff;
	localparam logic [15:0] PWM8_PERIOD = 16'h00ff;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] VAL_RST = 16'h0000;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [2:0] DIV8_LAST = 3'h7;
	typedef enum logic {OPMT_A_IDLE, OPMT_A_COUNT} opmt_a_state_t;
endpackage

// ### logic/opmt_clk_src.sv
// Count source selector with divide-by-8 and programmable prescaler.
`timescale 1ns/1ns
module opmt_clk_src (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [1:0] sel,
	input wire logic [3:0] div,
	input wire logic pre_en,
	input wire logic sub_clock_source,
	output logic tick
);
	typedef struct packed {
		logic [2:0] div8;
		logic [4:0] pre;
		logic sub_prev;
		logic tick;
	} opmt_src_t;

	opmt_src_t s;
	opmt_src_t next_s;
	logic p_tick;
	logic [4:0] pre_last;

	always_comb
	begin
		next_s = s;
		pre_last = 5'({div, 1'b0} - 5'h1);
		// The prescaler stays silent while disabled.
		p_tick = pre_en && (div == 4'h0 || s.pre == pre_last);
		next_s.div8 = 3'(s.div8 + 3'h1);
		next_s.pre = (p_tick || !pre_en) ? 5'h0 : 5'(s.pre + 5'h1);
		next_s.sub_prev = sub_clock_source;
		case (sel)
			opmt_pkg::SRC_F1: next_s.tick = 1'b1;
			opmt_pkg::SRC_F8: next_s.tick = s.div8 == opmt_pkg::DIV8_LAST;
			opmt_pkg::SRC_PRE: next_s.tick = p_tick;
			opmt_pkg::SRC_SUB: next_s.tick = sub_clock_source && !s.sub_prev;
			default: next_s.tick = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign tick = s.tick;
endmodule

// ### logic/opmt_timers.sv
// One-shot/PWM timer A and timer/measurement timer B behind AXI4-Lite.
`timescale 1ns/1ns
// How it works
// - One-shot counts down, interrupts, reloads, stops
// - Retrigger while counting reloads and continues
// - One-shot lasts n ticks; zero never runs
// - Triggers only while run; source selectable
// - Pulse pin high while counting; reads undefined
// - Stopped write loads both; running, reload only
// - Source select: undivided, div8, prescaler, sub
// - Prescaler: zero undivided, else divide 2n
// - PWM reloads at rise; triggers ignored running
// - 16-bit PWM: high n, period 65535
// - 8-bit PWM: prescale m+1, period 255
// - PWM starts on run or on trigger
// - PWM interrupts on each falling edge, except one caused by clearing run
// - Operating mode field selects measurement at 10
// - Measure select chooses edge pairs
// - Overflow flag sets; cleared by aged write
// - B timer counts n+1 ticks, reloads, interrupts
// - B runs on either run bit; timer reads live, measure reads capture
module opmt_timers (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic sub_clock_source,
	input wire logic a_trigger_input_pin,
	input wire logic b2_overflow,
	input wire logic a_prev_overflow,
	input wire logic a_next_overflow,
	input wire logic b_pulse_input_pin,
	output logic a_pulse_output_pin,
	output logic a_irq,
	output logic b_irq,
	output logic b_underflow
);
	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [9:0] waddr;
		logic [15:0] wdat;
		logic [1:0] wstb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [15:0] rdata;
		logic [7:0] presc;
		logic [7:0] a_mode;
		logic a_run;
		logic [1:0] a_trgsel;
		logic [15:0] a_reload;
		logic [15:0] a_cnt;
		logic [15:0] a_per;
		logic [7:0] a_pre;
		opmt_pkg::opmt_a_state_t a_state;
		logic a_out;
		logic a_irq;
		logic a_pin_prev;
		logic [7:0] b_mode;
		logic b_run;
		logic [15:0] b_reload;
		logic [15:0] b_cnt;
		logic b_ovf;
		logic b_ovf_aged;
		logic b_edge_seen;
		logic b_pin_prev;
		logic b_irq;
		logic b_uf;
	} opmt_state_t;

	opmt_state_t s;
	opmt_state_t n;
	logic a_tick;
	logic b_tick;

	// Merges the written byte lanes into a 16-bit register.
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [15:0] dat, input logic [1:0] stb);
		merge16 = {stb[1] ? dat[15:8] : old[15:8],
			stb[0] ? dat[7:0] : old[7:0]};
	endfunction

	// Picks the edge of a synchronous pin, rising or falling.
	function automatic logic edge_of(input logic pin, input logic prev,
		input logic fall);
		edge_of = (pin != prev) && (pin != fall);
	endfunction

	opmt_clk_src u_src_a (
		.aclk(aclk),
		.aresetn(aresetn),
		.sel(s.a_mode[opmt_pkg::F_SRC +: 2]),
		.div(s.presc[opmt_pkg::F_DIV +: 4]),
		.pre_en(s.presc[opmt_pkg::F_PRE_EN]),
		.sub_clock_source(sub_clock_source),
		.tick(a_tick)
	);

	opmt_clk_src u_src_b (
		.aclk(aclk),
		.aresetn(aresetn),
		.sel(s.b_mode[opmt_pkg::F_SRC +: 2]),
		.div(s.presc[opmt_pkg::F_DIV +: 4]),
		.pre_en(s.presc[opmt_pkg::F_PRE_EN]),
		.sub_clock_source(sub_clock_source),
		.tick(b_tick)
	);

	always_comb
	begin
		logic do_wr;
		logic os_sw;
		logic hw_trg;
		logic trg;
		logic pwm8;
		logic step;
		logic [15:0] width;
		logic [15:0] period;
		logic [1:0] a_op;
		logic [1:0] b_op;
		logic b_edge;
		logic b_rise;
		logic b_fall;
		n = s;
		do_wr = s.aw_got && s.w_got && !s.bvalid;
		os_sw = 1'b0;
		hw_trg = 1'b0;
		trg = 1'b0;
		step = 1'b0;
		b_edge = 1'b0;
		a_op = s.a_mode[opmt_pkg::F_OP +: 2];
		b_op = s.b_mode[opmt_pkg::F_OP +: 2];
		pwm8 = s.a_mode[opmt_pkg::F_PWM8];
		width = opmt_pkg::VAL_RST;
		period = opmt_pkg::VAL_RST;
		b_rise = 1'b0;
		b_fall = 1'b0;
		n.a_irq = 1'b0;
		n.b_irq = 1'b0;
		n.b_uf = 1'b0;
		// ----------------------------------------------------------
		// Bus slave
		// ----------------------------------------------------------
		if (s.bvalid && bready)
			n.bvalid = 1'b0;
		if (awvalid && awready)
		begin
			n.aw_got = 1'b1;
			n.waddr = awaddr[11:2];
		end
		if (wvalid && wready)
		begin
			n.w_got = 1'b1;
			n.wdat = wdata[15:0];
			n.wstb = wstrb[1:0];
		end
		if (do_wr)
		begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = opmt_pkg::RESP_OKAY;
			case (s.waddr)
				opmt_pkg::IDX_A_VALUE:
				begin
					n.a_reload = merge16(s.a_reload, s.wdat, s.wstb);
					if (s.a_state == opmt_pkg::OPMT_A_IDLE)
						n.a_cnt = n.a_reload;
				end
				opmt_pkg::IDX_A_MODE:
					if (s.wstb[0])
						n.a_mode = s.wdat[7:0];
				opmt_pkg::IDX_START_PRI:
				begin
					if (s.wstb[0])
					begin
						n.a_run = s.wdat[opmt_pkg::F_A_RUN];
						n.b_run = s.wdat[opmt_pkg::F_B_RUN];
					end
				end
				opmt_pkg::IDX_START_SEC:
					if (s.wstb[0])
						n.b_run = s.wdat[opmt_pkg::F_B_RUN2];
				opmt_pkg::IDX_ONESHOT:
				begin
					if (s.wstb[0])
					begin
						os_sw = s.wdat[opmt_pkg::F_OS_START];
						n.a_trgsel = s.wdat[opmt_pkg::F_TRGSEL +: 2];
					end
				end
				opmt_pkg::IDX_B_VALUE:
				begin
					if (s.b_mode[opmt_pkg::F_OP +: 2] !=
						opmt_pkg::B_OP_MEASURE)
					begin
						n.b_reload = merge16(s.b_reload, s.wdat,
							s.wstb);
						if (!s.b_run)
							n.b_cnt = n.b_reload;
					end
				end
				opmt_pkg::IDX_B0_MODE:
				begin
					if (s.wstb[0])
					begin
						n.b_mode = s.wdat[7:0];
						// Only an aged flag on a running timer clears.
						if (!s.wdat[opmt_pkg::F_OVF] && s.b_ovf_aged &&
							s.b_run)
							n.b_ovf = 1'b0;
					end
				end
				opmt_pkg::IDX_PRESC:
					if (s.wstb[0])
						n.presc = s.wdat[7:0];
				default:
					n.bresp = opmt_pkg::RESP_SLVERR;
			endcase
		end
		if (s.rvalid && rready)
			n.rvalid = 1'b0;
		if (arvalid && arready)
		begin
			n.rvalid = 1'b1;
			n.rresp = opmt_pkg::RESP_OKAY;
			n.rdata = opmt_pkg::VAL_RST;
			case (araddr[11:2])
				// Timer A value reads back undefined, shown as zero.
				opmt_pkg::IDX_A_VALUE: n.rdata = opmt_pkg::VAL_RST;
				opmt_pkg::IDX_A_MODE: n.rdata[7:0] = s.a_mode;
				opmt_pkg::IDX_START_PRI:
				begin
					n.rdata[opmt_pkg::F_A_RUN] = s.a_run;
					n.rdata[opmt_pkg::F_B_RUN] = s.b_run;
				end
				opmt_pkg::IDX_START_SEC:
					n.rdata[opmt_pkg::F_B_RUN2] = s.b_run;
				opmt_pkg::IDX_ONESHOT:
					n.rdata[opmt_pkg::F_TRGSEL +: 2] = s.a_trgsel;
				opmt_pkg::IDX_B_VALUE:
					n.rdata = (s.b_mode[opmt_pkg::F_OP +: 2] ==
						opmt_pkg::B_OP_MEASURE) ? s.b_reload : s.b_cnt;
				opmt_pkg::IDX_B0_MODE:
				begin
					n.rdata[7:0] = s.b_mode;
					n.rdata[opmt_pkg::F_OVF] = s.b_ovf;
				end
				opmt_pkg::IDX_PRESC: n.rdata[7:0] = s.presc;
				default: n.rresp = opmt_pkg::RESP_SLVERR;
			endcase
		end
		// ----------------------------------------------------------
		// Timer A: one-shot and PWM
		// ----------------------------------------------------------
		n.a_pin_prev = a_trigger_input_pin;
		case (s.a_trgsel)
			opmt_pkg::TRG_PIN:
				hw_trg = edge_of(a_trigger_input_pin, s.a_pin_prev,
					s.a_mode[opmt_pkg::F_PIN_FALL]);
			opmt_pkg::TRG_B2: hw_trg = b2_overflow;
			opmt_pkg::TRG_PREV: hw_trg = a_prev_overflow;
			opmt_pkg::TRG_NEXT: hw_trg = a_next_overflow;
			default: hw_trg = 1'b0;
		endcase
		width = pwm8 ? {8'h00, n.a_reload[15:8]} : n.a_reload;
		period = pwm8 ? opmt_pkg::PWM8_PERIOD : opmt_pkg::PWM16_PERIOD;
		if (!n.a_run)
			n.a_state = opmt_pkg::OPMT_A_IDLE;
		else
		begin
			case (a_op)
				opmt_pkg::A_OP_ONESHOT:
				begin
					trg = s.a_mode[opmt_pkg::F_TRG_USE] ? hw_trg : os_sw;
					if (trg && n.a_reload != opmt_pkg::VAL_RST)
					begin
						n.a_cnt = n.a_reload;
						n.a_state = opmt_pkg::OPMT_A_COUNT;
					end
					else if (s.a_state == opmt_pkg::OPMT_A_COUNT && a_tick)
					begin
						if (s.a_cnt <= 16'h0001)
						begin
							n.a_irq = 1'b1;
							n.a_cnt = n.a_reload;
							n.a_state = opmt_pkg::OPMT_A_IDLE;
						end
						else
							n.a_cnt = 16'(s.a_cnt - 16'h0001);
					end
				end
				opmt_pkg::A_OP_PWM:
				begin
					// Retriggers while running are ignored.
					trg = s.a_mode[opmt_pkg::F_TRG_USE] ? hw_trg : 1'b1;
					if (s.a_state == opmt_pkg::OPMT_A_IDLE)
					begin
						if (trg)
						begin
							n.a_state = opmt_pkg::OPMT_A_COUNT;
							n.a_per = 16'(period - 16'h0001);
							n.a_pre = 8'h00;
							n.a_cnt = width;
						end
					end
					else if (a_tick)
					begin
						step = !pwm8 || s.a_pre == n.a_reload[7:0];
						n.a_pre = step ? 8'h00 : 8'(s.a_pre + 8'h01);
						if (step && s.a_per == opmt_pkg::VAL_RST)
						begin
							n.a_per = 16'(period - 16'h0001);
							n.a_cnt = width;
						end
						else if (step)
						begin
							n.a_per = 16'(s.a_per - 16'h0001);
							if (s.a_cnt != opmt_pkg::VAL_RST)
								n.a_cnt = 16'(s.a_cnt - 16'h0001);
						end
					end
				end
				default:
					n.a_state = opmt_pkg::OPMT_A_IDLE;
			endcase
		end
		n.a_out = n.a_run && n.a_state == opmt_pkg::OPMT_A_COUNT &&
			(a_op == opmt_pkg::A_OP_ONESHOT ||
			n.a_cnt != opmt_pkg::VAL_RST);
		if (a_op == opmt_pkg::A_OP_PWM && n.a_run && s.a_out && !n.a_out)
			n.a_irq = 1'b1;
		// ----------------------------------------------------------
		// Timer B: timer and measurement
		// ----------------------------------------------------------
		n.b_pin_prev = b_pulse_input_pin;
		b_rise = edge_of(b_pulse_input_pin, s.b_pin_prev, 1'b0);
		b_fall = edge_of(b_pulse_input_pin, s.b_pin_prev, 1'b1);
		case (s.b_mode[opmt_pkg::F_MEAS +: 2])
			opmt_pkg::MEAS_FALL: b_edge = b_fall;
			opmt_pkg::MEAS_RISE: b_edge = b_rise;
			opmt_pkg::MEAS_BOTH: b_edge = b_rise || b_fall;
			default: b_edge = 1'b0;
		endcase
		if (b_tick && s.b_ovf)
			n.b_ovf_aged = 1'b1;
		if (!s.b_run)
			n.b_edge_seen = 1'b0;
		else
		begin
			case (b_op)
				opmt_pkg::B_OP_TIMER:
				begin
					if (b_tick && s.b_cnt == opmt_pkg::VAL_RST)
					begin
						n.b_cnt = n.b_reload;
						n.b_irq = 1'b1;
						n.b_uf = 1'b1;
					end
					else if (b_tick)
						n.b_cnt = 16'(s.b_cnt - 16'h0001);
				end
				opmt_pkg::B_OP_MEASURE:
				begin
					if (b_edge)
					begin
						n.b_reload = s.b_cnt;
						n.b_cnt = opmt_pkg::VAL_RST;
						n.b_irq = s.b_edge_seen;
						n.b_edge_seen = 1'b1;
					end
					else if (b_tick)
					begin
						n.b_cnt = 16'(s.b_cnt + 16'h0001);
						if (s.b_cnt == opmt_pkg::CNT_MAX)
						begin
							n.b_ovf = 1'b1;
							n.b_ovf_aged = 1'b0;
							n.b_irq = 1'b1;
							n.b_uf = 1'b1;
						end
					end
				end
				default:
					n.b_cnt = s.b_cnt;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s <= '0;
			s.a_state <= opmt_pkg::OPMT_A_IDLE;
		end
		else
			s <= n;
	end

	assign awready = !s.aw_got && !s.bvalid;
	assign wready = !s.w_got && !s.bvalid;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = !s.rvalid;
	assign rvalid = s.rvalid;
	assign rresp = s.rresp;
	assign rdata = {16'h0000, s.rdata};
	assign a_pulse_output_pin = s.a_out;
	assign a_irq = s.a_irq;
	assign b_irq = s.b_irq;
	assign b_underflow = s.b_uf;
endmodule

// ### tb/opmt_props.sv
// Port-level checks for the one-shot, PWM and measurement timer block.
`timescale 1ns/1ns
module opmt_props (
	input logic aclk,
	input logic aresetn,
	input logic awvalid,
	input logic awready,
	input logic wvalid,
	input logic wready,
	input logic [1:0] bresp,
	input logic bvalid,
	input logic bready,
	input logic arvalid,
	input logic arready,
	input logic [31:0] rdata,
	input logic rvalid,
	input logic rready,
	input logic a_pulse_output_pin,
	input logic a_irq,
	input logic b_irq,
	input logic b_underflow
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_wr_ans;
		awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
	endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
	property p_rd_ans; arvalid && arready |=> rvalid; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	// A second write must not slip in while the previous answer waits.
	property p_no_take; bvalid |-> !awready && !wready; endproperty
	a_no_take: assert property (p_no_take) else $error("write taken early");
	property p_rd_hi; rvalid |-> rdata[31:16] == 16'h0000; endproperty
	a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
	property p_irq_fall; a_irq |-> $fell(a_pulse_output_pin); endproperty
	a_irq_fall: assert property (p_irq_fall)
		else $error("timer A request without falling pulse");
	property p_b_irq; b_underflow |-> b_irq; endproperty
	a_b_irq: assert property (p_b_irq)
		else $error("underflow without request");

	c_os: cover property (a_irq && !a_pulse_output_pin);
	c_bu: cover property (b_underflow);
	c_meas: cover property (b_irq && !b_underflow);
	c_err: cover property (bvalid && bresp == opmt_pkg::RESP_SLVERR);
endmodule

bind opmt_timers opmt_props i_props (.aclk(aclk), .aresetn(aresetn),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
	.bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
	.arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
	.a_pulse_output_pin(a_pulse_output_pin), .a_irq(a_irq), .b_irq(b_irq),
	.b_underflow(b_underflow));

// ### tb/opmt_pins.sv
// Behavioural model of the trigger, pulse input and sub clock pins.
`timescale 1ns/1ns
module opmt_pins (
	input logic aclk,
	input logic go,
	input logic [1:0] sel,
	output logic trg,
	output logic b2,
	output logic prv,
	output logic nxt,
	output logic bpin,
	output logic sub
);
	int k = 0;

	initial {trg, b2, prv, nxt, bpin, sub} = '0;
	// The sub clock runs free with a period of ten bus clocks, so every
	// count derived from it is an exact multiple of ten.
	always @(posedge aclk)
	begin
		k <= k + 1;
		sub <= (k % 10) >= 5;
		bpin <= k[6];
		trg <= go && sel == opmt_pkg::TRG_PIN;
		b2 <= go && sel == opmt_pkg::TRG_B2;
		prv <= go && sel == opmt_pkg::TRG_PREV;
		nxt <= go && sel == opmt_pkg::TRG_NEXT;
	end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the one-shot, PWM and measurement timers.
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
	$display("unexpected %0t got %h exp %h", $time, g, e); end end
module testbench;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, go = 1'b0;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic [1:0] sel = '0, bresp, rresp, rs;
	logic awready, wready, bvalid, arready, rvalid, pout, a_irq, b_irq, b_uf;
	logic trg, b2, prv, nxt, bpin, sub;
	logic [15:0] d, h;
	int fails = 0, checks = 0, lo;
	logic [31:0] hi;
	int nv[4] = '{3, 1, 1, 1};
	int per[4] = '{4, 16, 8, 20};

	always #2 aclk = !aclk;

	opmt_timers i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'h3), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .sub_clock_source(sub),
		.a_trigger_input_pin(trg), .b2_overflow(b2), .a_prev_overflow(prv),
		.a_next_overflow(nxt), .b_pulse_input_pin(bpin),
		.a_pulse_output_pin(pout), .a_irq(a_irq), .b_irq(b_irq),
		.b_underflow(b_uf));
	opmt_pins i_pins (.aclk(aclk), .go(go), .sel(sel), .trg(trg), .b2(b2),
		.prv(prv), .nxt(nxt), .bpin(bpin), .sub(sub));

	task automatic end_sim;
		if (fails == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic lim(input int n);
		if (n >= 99)
		begin
			fails++;
			end_sim;
		end
	endtask

	// Both tasks leave one idle edge at the end so that a following call
	// never drives a handshake signal twice in one time step.
	task automatic wr(input logic [9:0] x, input logic [15:0] v);
		int n;
		logic b;
		n = 0;
		b = 1'b0;
		awaddr <= {x, 2'b00};
		wdata <= {16'h0000, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b && n < 99)
		begin
			@(posedge aclk);
			n++;
			rs = bresp;
			b = bvalid;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		@(posedge aclk);
		lim(n);
	endtask

	task automatic rd(input logic [9:0] x);
		int n;
		logic b;
		n = 0;
		b = 1'b0;
		araddr <= {x, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!b && n < 99)
		begin
			@(posedge aclk);
			n++;
			d = rdata[15:0];
			rs = rresp;
			b = rvalid;
			if (arready) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		@(posedge aclk);
		lim(n);
	endtask

	task automatic fire(input logic [1:0] s);
		sel <= s;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		hi += pout;
	endtask

	task automatic wirq(input int m);
		lo = 0;
		do
		begin
			@(posedge aclk);
			lo++;
			hi += pout;
		end while (!a_irq && lo < m);
	endtask

	task automatic wb(input int m);
		lo = 0;
		do
		begin
			@(posedge aclk);
			lo++;
		end while (!b_irq && lo < m);
	endtask

	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(opmt_pkg::IDX_A_MODE);
		`CHK(d, 16'h0000)
		wr(opmt_pkg::IDX_A_MODE, 16'h0006);
		rd(opmt_pkg::IDX_A_MODE);
		`CHK(d, 16'h0006)
		wr(10'h3ff, 16'h0001);
		`CHK(rs, opmt_pkg::RESP_SLVERR)
		rd(10'h3ff);
		`CHK(rs, opmt_pkg::RESP_SLVERR)
		wr(opmt_pkg::IDX_A_VALUE, 16'h0003);
		rd(opmt_pkg::IDX_A_VALUE);
		`CHK(d, 16'h0000)
		wr(opmt_pkg::IDX_START_PRI, 16'h0001);
		for (int s = 0; s < 4; s++)
		begin
			wr(opmt_pkg::IDX_ONESHOT, 16'(s << 4));
			hi = 0;
			fire(s[1:0]);
			wirq(20);
			`CHK(hi, 3)
			`CHK(a_irq, 1'b1)
		end
		hi = 0;
		wirq(30);
		`CHK(hi, 0)
		wr(opmt_pkg::IDX_A_VALUE, 16'h0006);
		hi = 0;
		fire(2'h3);
		wirq(2);
		fire(2'h3);
		wirq(40);
		`CHK(hi, 9)
		wr(opmt_pkg::IDX_A_VALUE, 16'h0000);
		hi = 0;
		fire(2'h3);
		wirq(30);
		`CHK(hi, 0)
		wr(opmt_pkg::IDX_A_VALUE, 16'h0032);
		fire(2'h3);
		wirq(4);
		// Counting has run several ticks, so a new value may be written.
		wr(opmt_pkg::IDX_A_VALUE, 16'h0002);
		wirq(3);
		`CHK(a_irq, 1'b0)
		wr(opmt_pkg::IDX_START_PRI, 16'h0000);
		@(posedge aclk);
		`CHK(pout, 1'b0)
		hi = 0;
		fire(2'h3);
		wirq(10);
		`CHK(hi, 0)
		wr(opmt_pkg::IDX_A_MODE, 16'h0002);
		wr(opmt_pkg::IDX_A_VALUE, 16'h0005);
		wr(opmt_pkg::IDX_START_PRI, 16'h0001);
		wr(opmt_pkg::IDX_ONESHOT, 16'h0001);
		wirq(20);
		`CHK(a_irq, 1'b1)
		wr(opmt_pkg::IDX_START_PRI, 16'h0000);
		wr(opmt_pkg::IDX_A_VALUE, 16'h0004);
		wr(opmt_pkg::IDX_A_MODE, 16'h0003);
		wr(opmt_pkg::IDX_START_PRI, 16'h0001);
		wirq(99);
		hi = 0;
		wirq(70000);
		`CHK(hi, 4)
		`CHK(lo, 65535)
		wr(opmt_pkg::IDX_START_PRI, 16'h0000);
		wr(opmt_pkg::IDX_A_VALUE, 16'h0301);
		wr(opmt_pkg::IDX_A_MODE, 16'h0017);
		wr(opmt_pkg::IDX_START_PRI, 16'h0001);
		fire(2'h0);
		wirq(600);
		fire(2'h0);
		hi = 0;
		wirq(600);
		`CHK(hi, 6)
		`CHK(lo, 255 * 2 - 1)
		wr(opmt_pkg::IDX_PRESC, 16'h0082);
		for (int i = 0; i < 4; i++)
		begin
			wr(opmt_pkg::IDX_START_SEC, 16'h0000);
			wr(opmt_pkg::IDX_B_VALUE, 16'(nv[i]));
			wr(opmt_pkg::IDX_B0_MODE, 16'(i << 6));
			wr(opmt_pkg::IDX_START_SEC, 16'h0001);
			wb(99);
			wb(99);
			`CHK(lo, per[i])
			`CHK(b_uf, 1'b1)
		end
		wr(opmt_pkg::IDX_START_SEC, 16'h0000);
		wr(opmt_pkg::IDX_START_PRI, 16'h0002);
		wb(99);
		wb(99);
		`CHK(lo, 20)
		wr(opmt_pkg::IDX_START_PRI, 16'h0000);
		rd(opmt_pkg::IDX_B_VALUE);
		h = d;
		repeat (40) @(posedge aclk);
		rd(opmt_pkg::IDX_B_VALUE);
		`CHK(d, h)
		// The pulse input toggles every 64 clocks; the edge cycle itself
		// restarts the count, so one tick less than the interval is seen.
		for (int i = 0; i < 3; i++)
		begin
			wr(opmt_pkg::IDX_START_SEC, 16'h0000);
			wr(opmt_pkg::IDX_B0_MODE, 16'(2 | (i << 2)));
			wr(opmt_pkg::IDX_START_SEC, 16'h0001);
			wb(300);
			`CHK(b_irq, 1'b1)
			rd(opmt_pkg::IDX_B_VALUE);
			`CHK(d, (i == 2) ? 16'h003f : 16'h007f)
		end
		end_sim;
	end
endmodule
